// ---- core/rpi_pkg.sv ----
/*
 Shared constants, types and register map of the recloser panel interlock.
 Assumes a single 100 MHz core clock and a synchronous active-high reset.
*/
package rpi_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam longint CLK_HZ = 100_000_000;
   localparam longint WINDOW_S = 10;
   localparam longint PSAVE_MIN = 10;
   localparam longint SEC_PER_MIN = 60;
   localparam longint MS_PER_S = 1000;
   localparam longint WINDOW_CYC = WINDOW_S * CLK_HZ;
   localparam longint PSAVE_CYC = PSAVE_MIN * SEC_PER_MIN * CLK_HZ;
   localparam longint CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int TW = 36;
   localparam int MSW = 17;
   localparam logic [8:0] BLINK_MS = 9'h1F4;

   // ****************************************
   // Register map
   // ****************************************
   localparam int AW = 8;
   localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
   localparam logic [AW-1:0] ADDR_HLT_DLY = 8'h04;
   localparam logic [AW-1:0] ADDR_CMD = 8'h08;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h0C;
   localparam int CTRL_MODE = 0;
   localparam int CTRL_PSAVE_EN = 2;
   localparam int CTRL_COLD_LOAD_PICKUP_EN = 3;
   localparam int CTRL_FAST_OFF = 4;
   localparam int CMD_HLT_SET = 0;
   localparam int CMD_HLT_CLR = 1;
   localparam int CMD_GND_SET = 2;
   localparam int CMD_GND_CLR = 3;
   localparam int CMD_NRC_SET = 4;
   localparam int CMD_NRC_CLR = 5;
   localparam int CMD_COLD_LOAD_PICKUP_CLR = 6;
   localparam int CMD_CLOSE = 8;
   localparam int CMD_TRIP = 12;
   localparam int ST_HLT_SRC = 0;
   localparam int ST_LOCK = 4;
   localparam int ST_FUNC = 8;
   localparam int ST_WIN = 17;
   localparam int ST_COLD_LOAD_PICKUP = 18;
   localparam int ST_DARK = 19;
   localparam int ST_HLT = 20;

   // ****************************************
   // Function keys and modes
   // ****************************************
   localparam int NFK = 9;
   localparam int FK_GND = 0;
   localparam int FK_NRC = 1;
   localparam int FK_SUP = 2;
   localparam int FK_PHS = 3;
   localparam logic [2:0] PH_ALL = 3'h7;

   typedef enum logic [1:0] {
      MODE_GANGED = 2'h0,
      MODE_SP3L = 2'h1,
      MODE_SPSL = 2'h2
   } rpi_mode_t;

   typedef enum logic {
      WIN_IDLE = 1'h0,
      WIN_OPEN = 1'h1
   } rpi_win_t;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic hlt_toggle;
      logic trip_pb;
      logic close_pb;
      logic change_key;
      logic [NFK-1:0] fkey;
      logic [2:0] handle_open;
      logic scada_hlt;
      logic io_gnd_blk;
      logic io_non_recl;
   } rpi_pins_t;

   typedef struct packed {
      logic [2:0] pickup;
      logic [2:0] first_time_current_curve_trip;
      logic [2:0] auto_close;
      logic [2:0] closed;
      logic [2:0] seq_lockout;
   } rpi_prot_t;

   typedef struct packed {
      logic [2:0] close;
      logic [2:0] trip;
      logic [2:0] seq_home;
   } rpi_cmd_t;

   typedef struct packed {
      logic hlt_one_shot;
      logic cold_load_pickup;
      logic non_recl;
      logic fast_off;
      logic gnd_off;
   } rpi_prof_t;

   typedef struct packed {
      logic hlt;
      logic open;
      logic closed;
      logic lockout;
      logic [NFK-1:0] fkey;
   } rpi_leds_t;

endpackage

// ---- core/rpi_sync.sv ----
/*
 Three-stage synchroniser for panel and discrete pins.
 Assumes asynchronous inputs; output rises only once stages two and three agree high, and falls as soon as they differ.
*/
`timescale 1ns/1ns
`default_nettype none
module rpi_sync
   import rpi_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] out;
   } rpi_sync_st_t;

   rpi_sync_st_t q;
   rpi_sync_st_t d;

   always_comb
   begin
      d = q;
      d.s1 = i_async;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // Agreement of two settled stages filters a single high metastable sample; a single low sample clears the output
      d.out = (q.s2 & q.s3) | (q.out & ~(q.s2 ^ q.s3));
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_sync = q.out;

endmodule
`default_nettype wire

// ---- core/rpi_timer.sv ----
/*
 One-shot down counter used for the change window and the power-save timeout.
 Assumes load and stop are single-cycle pulses from the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module rpi_timer
   import rpi_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_load,
   input wire logic i_stop,
   input wire logic [TW-1:0] i_count,
   output logic o_busy,
   output logic o_done
);

   typedef struct packed {
      logic [TW-1:0] cnt;
      logic busy;
      logic done;
   } rpi_tmr_st_t;

   rpi_tmr_st_t q;
   rpi_tmr_st_t d;

   always_comb
   begin
      d = q;
      d.done = 1'b0;
      if (i_load)
      begin
         d.cnt = i_count;
         d.busy = 1'b1;
      end
      else if (i_stop)
      begin
         d.busy = 1'b0;
      end
      else if (q.busy)
      begin
         d.cnt = q.cnt - {{(TW-1){1'b0}}, 1'b1};
         if (q.cnt <= {{(TW-1){1'b0}}, 1'b1})
         begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_busy = q.busy;
   assign o_done = q.done;

endmodule
`default_nettype wire

// ---- core/rpi_panel.sv ----
/*
 Operator-panel command and interlock logic of a three-pole recloser control.
 Assumes protection sequencing, curves and metering live outside; pins are async.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// RL1: live-work tag blocks every close
// RL2: tag activation never trips by itself
// RL3: tag gives one trip on faster curve
// RL4: tag overrides cold-load, reclose-inhibit, fast-off
// RL5: tag active while any source requests
// RL6: each source clears only its own request
// RL7: power save darkens LEDs except tag
// RL8: trip button opens and locks out
// RL9: close button homes sequence and closes
// RL10: close malfunction alarm blocks closing
// RL11: close from lockout starts cold-load pickup
// RL12: key LEDs show function state always; power save blanks them
// RL13: change key opens ten-second toggle window
// RL14: one toggle per window, then closes
// RL15: ground block disables ground sensing
// RL16: reclose inhibit stops automatic reclosing only
// RL17: supervisory off blocks rear and discrete commands; tag requests and cold-load clear still pass
// RL18: supervisory off changed only from panel
// RL19: single-pole lockout acts on selected phases
// RL20: three-pole lockout modes select all phases
// RL21: handle open locks out all phases
// RL22: single-pole handle open affects one phase
// RL23: unchosen window keeps prior setting
// RL24: handle close position never closes
module rpi_panel
   import rpi_pkg::*;
#(
   parameter logic [TW-1:0] P_WINDOW_CYC = TW'(WINDOW_CYC),
   parameter logic [TW-1:0] P_PSAVE_CYC = TW'(PSAVE_CYC),
   parameter logic [MSW-1:0] P_CYC_PER_MS = MSW'(CYC_PER_MS)
)
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic [AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire rpi_pins_t i_pins,
   input wire rpi_prot_t i_prot,
   input wire logic i_close_malf,
   output rpi_cmd_t o_cmd,
   output rpi_prof_t o_prof,
   output rpi_leds_t o_leds
);

   typedef struct packed {
      rpi_mode_t mode;
      logic psave_off;
      logic cold_load_pickup_en;
      logic fast_off;
      logic [15:0] hlt_dly;
      logic hlt_ser;
      logic [NFK-1:0] func;
      logic [2:0] lockout;
      logic cold_load_pickup;
      rpi_win_t win;
      rpi_pins_t prev;
      logic [MSW-1:0] ms_div;
      logic [15:0] hlt_ms;
      logic [8:0] blink_ms;
      logic blink;
      logic dark;
      logic [31:0] rdata;
      rpi_cmd_t cmd;
      rpi_prof_t prof;
      rpi_leds_t leds;
   } rpi_st_t;

   rpi_st_t q;
   rpi_st_t d;
   rpi_pins_t p;
   rpi_pins_t rise;
   rpi_pins_t fall;
   logic win_load;
   logic win_stop;
   logic win_done;
   logic ps_load;
   logic ps_busy;
   logic ps_done;

   // Steady when all three agree, blinking when only some are set
   function automatic logic led3(input logic [2:0] v, input logic blink);
      led3 = (&v) | ((|v) & blink);
   endfunction

   // Lowest set bit, so simultaneous presses toggle only one function
   function automatic logic [NFK-1:0] first_one(input logic [NFK-1:0] v);
      first_one = v & (~v + {{(NFK-1){1'b0}}, 1'b1});
   endfunction

   rpi_sync #(
      .W($bits(rpi_pins_t))
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_async(i_pins),
      .o_sync(p)
   );

   rpi_timer u_win (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_load(win_load),
      .i_stop(win_stop),
      .i_count(P_WINDOW_CYC),
      .o_busy(),
      .o_done(win_done)
   );

   rpi_timer u_psave (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_load(ps_load),
      .i_stop(1'b0),
      .i_count(P_PSAVE_CYC),
      .o_busy(ps_busy),
      .o_done(ps_done)
   );

   assign rise = rpi_pins_t'(p & ~q.prev);
   assign fall = rpi_pins_t'(~p & q.prev);

   always_comb
   begin
      logic spsl;
      logic sup_off;
      logic hlt;
      logic wr_cmd;
      logic panel_op;
      logic hlt_fire;
      logic ms_tick;
      logic close_ok;
      logic [2:0] sel;
      logic [2:0] sup_close;
      logic [2:0] sup_trip;
      logic [2:0] close_req;
      logic [2:0] trips;
      logic [2:0] lock_set;
      logic [2:0] htrip;
      logic [NFK-1:0] pick;
      logic [31:0] st;
      spsl = 1'b0;
      sup_off = 1'b0;
      hlt = 1'b0;
      wr_cmd = 1'b0;
      panel_op = 1'b0;
      hlt_fire = 1'b0;
      ms_tick = 1'b0;
      close_ok = 1'b0;
      sel = '0;
      sup_close = '0;
      sup_trip = '0;
      close_req = '0;
      trips = '0;
      lock_set = '0;
      htrip = '0;
      pick = '0;
      st = '0;
      d = q;
      d.prev = p;
      win_load = 1'b0;
      win_stop = 1'b0;

      spsl = (q.mode == MODE_SPSL);
      sup_off = q.func[FK_SUP];
      // RL20 all phases held
      sel = spsl ? q.func[FK_PHS+:3] : PH_ALL;

      // ****************************************
      // Register bus
      // ****************************************
      if (i_wr)
      begin
         if (i_addr == ADDR_CTRL)
         begin
            d.mode = rpi_mode_t'(i_wdata[CTRL_MODE+:2]);
            d.psave_off = ~i_wdata[CTRL_PSAVE_EN];
            d.cold_load_pickup_en = i_wdata[CTRL_COLD_LOAD_PICKUP_EN];
            d.fast_off = i_wdata[CTRL_FAST_OFF];
         end
         else if (i_addr == ADDR_HLT_DLY)
         begin
            d.hlt_dly = i_wdata[15:0];
         end
         else if (i_addr == ADDR_CMD)
         begin
            wr_cmd = 1'b1;
         end
      end
      // RL17 rear commands gated
      if (wr_cmd && !sup_off)
      begin
         sup_close = i_wdata[CMD_CLOSE+:3];
         sup_trip = i_wdata[CMD_TRIP+:3];
      end

      // ****************************************
      // Live-work tag
      // ****************************************
      // RL6 serial request owned by serial
      if (wr_cmd)
      begin
         d.hlt_ser = (q.hlt_ser & ~i_wdata[CMD_HLT_CLR]) | i_wdata[CMD_HLT_SET];
      end
      // RL5 any source holds
      hlt = p.hlt_toggle | q.hlt_ser | p.scada_hlt;

      d.ms_div = q.ms_div + {{(MSW-1){1'b0}}, 1'b1};
      if (q.ms_div >= P_CYC_PER_MS - {{(MSW-1){1'b0}}, 1'b1})
      begin
         d.ms_div = '0;
         ms_tick = 1'b1;
      end
      if (hlt && (|i_prot.pickup))
      begin
         if (ms_tick && q.hlt_ms != 16'hFFFF)
         begin
            d.hlt_ms = q.hlt_ms + 16'h0001;
         end
      end
      else
      begin
         d.hlt_ms = '0;
      end
      // RL3 faster of delay or first curve
      hlt_fire = hlt && (|i_prot.pickup) &&
                 ((q.hlt_ms >= q.hlt_dly) || (|i_prot.first_time_current_curve_trip));
      // RL2 trip only on a fault, never on activation
      if (hlt_fire)
      begin
         htrip = (spsl ? i_prot.pickup : PH_ALL) & ~q.lockout;
      end

      // ****************************************
      // Trip and lockout
      // ****************************************
      // RL8 trip button
      // RL19 selected phases only
      if (rise.trip_pb)
      begin
         trips = sel;
      end
      if (|rise.handle_open)
      begin
         // RL22 single phase
         // RL21 all three lock out
         trips = trips | (spsl ? rise.handle_open : PH_ALL);
      end
      trips = trips | htrip | sup_trip;
      lock_set = trips | i_prot.seq_lockout;
      if (!spsl && (|lock_set))
      begin
         lock_set = PH_ALL;
      end

      // ****************************************
      // Close
      // ****************************************
      // RL1 tag blocks close
      // RL10 malfunction blocks close
      close_ok = !hlt && !i_close_malf;
      // RL9 close button
      if (rise.close_pb)
      begin
         close_req = sel;
      end
      // RL16 only automatic reclosing inhibited
      if (!q.func[FK_NRC])
      begin
         close_req = close_req | (i_prot.auto_close & ~q.lockout);
      end
      // RL24 closes come only from commands
      close_req = close_req | sup_close;
      d.cmd.close = close_ok ? close_req : 3'h0;
      d.cmd.trip = trips;
      d.cmd.seq_home = (close_ok && rise.close_pb) ? sel : 3'h0;
      // Set wins over clear when a lockout arrives with a close
      d.lockout = (q.lockout & ~d.cmd.close) | lock_set;

      // RL11 cold-load start from lockout
      if (close_ok && rise.close_pb && q.cold_load_pickup_en && (|(sel & q.lockout)) &&
          (|(sel & ~i_prot.closed)))
      begin
         d.cold_load_pickup = 1'b1;
      end
      else if ((|lock_set) || (wr_cmd && i_wdata[CMD_COLD_LOAD_PICKUP_CLR]))
      begin
         d.cold_load_pickup = 1'b0;
      end

      // ****************************************
      // Change window and function keys
      // ****************************************
      case (q.win)
         WIN_IDLE:
         begin
            if (rise.change_key)
            begin
               d.win = WIN_OPEN;
               win_load = 1'b1;
            end
         end
         WIN_OPEN:
         begin
            // RL13 toggle within window
            // RL14 one change then close
            if (|rise.fkey)
            begin
               pick = first_one(rise.fkey);
               d.func = q.func ^ pick;
               d.win = WIN_IDLE;
               win_stop = 1'b1;
            end
            // RL23 timeout keeps setting
            else if (win_done)
            begin
               d.win = WIN_IDLE;
            end
         end
         default:
         begin
            d.win = WIN_IDLE;
         end
      endcase

      // RL18 supervisory off never set remotely
      if (wr_cmd && !sup_off)
      begin
         d.func[FK_GND] = (d.func[FK_GND] & ~i_wdata[CMD_GND_CLR]) |
                          i_wdata[CMD_GND_SET];
         d.func[FK_NRC] = (d.func[FK_NRC] & ~i_wdata[CMD_NRC_CLR]) |
                          i_wdata[CMD_NRC_SET];
      end
      if (!sup_off)
      begin
         d.func[FK_GND] = (d.func[FK_GND] & ~fall.io_gnd_blk) | rise.io_gnd_blk;
         d.func[FK_NRC] = (d.func[FK_NRC] & ~fall.io_non_recl) | rise.io_non_recl;
      end

      // ****************************************
      // Profile outputs
      // ****************************************
      // RL4 tag overrides cold-load, reclose-inhibit and fast-off
      d.prof.hlt_one_shot = hlt;
      d.prof.cold_load_pickup = q.cold_load_pickup & ~hlt;
      d.prof.non_recl = q.func[FK_NRC] & ~hlt;
      d.prof.fast_off = q.fast_off & ~hlt;
      // RL15 ground sensing off
      d.prof.gnd_off = q.func[FK_GND];

      // ****************************************
      // Indicators and power save
      // ****************************************
      if (ms_tick)
      begin
         d.blink_ms = q.blink_ms + 9'h001;
         if (q.blink_ms >= BLINK_MS - 9'h001)
         begin
            d.blink_ms = '0;
            d.blink = ~q.blink;
         end
      end
      panel_op = rise.trip_pb | rise.close_pb | rise.change_key | (|rise.fkey) |
                 (p.hlt_toggle ^ q.prev.hlt_toggle);
      ps_load = panel_op | (!ps_busy && !q.dark);
      // RL7 dark after idle
      if (panel_op || q.psave_off)
      begin
         d.dark = 1'b0;
      end
      else if (ps_done)
      begin
         d.dark = 1'b1;
      end
      d.leds.hlt = hlt;
      d.leds.open = led3(~i_prot.closed, q.blink) & ~q.dark;
      d.leds.closed = led3(i_prot.closed, q.blink) & ~q.dark;
      d.leds.lockout = led3(q.lockout, q.blink) & ~q.dark;
      // RL12 state regardless of source
      d.leds.fkey = q.func & {NFK{~q.dark}};
      d.leds.fkey[FK_PHS+:3] = sel & {3{~q.dark}};

      // ****************************************
      // Read data
      // ****************************************
      st[ST_HLT_SRC+:3] = {p.scada_hlt, q.hlt_ser, p.hlt_toggle};
      st[ST_LOCK+:3] = q.lockout;
      st[ST_FUNC+:NFK] = q.func;
      st[ST_WIN] = (q.win == WIN_OPEN);
      st[ST_COLD_LOAD_PICKUP] = q.cold_load_pickup;
      st[ST_DARK] = q.dark;
      st[ST_HLT] = hlt;
      d.rdata = '0;
      if (i_rd)
      begin
         if (i_addr == ADDR_CTRL)
         begin
            d.rdata[CTRL_MODE+:2] = q.mode;
            d.rdata[CTRL_PSAVE_EN] = ~q.psave_off;
            d.rdata[CTRL_COLD_LOAD_PICKUP_EN] = q.cold_load_pickup_en;
            d.rdata[CTRL_FAST_OFF] = q.fast_off;
         end
         else if (i_addr == ADDR_HLT_DLY)
         begin
            d.rdata[15:0] = q.hlt_dly;
         end
         else if (i_addr == ADDR_STATUS)
         begin
            d.rdata = st;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_rdata = q.rdata;
   assign o_cmd = q.cmd;
   assign o_prof = q.prof;
   assign o_leds = q.leds;

endmodule
`default_nettype wire

// ---- bench/rpi_panel_asserts.sv ----
/*
 Port-level checker of the panel interlock, bound onto rpi_panel.
 Assumes one clock domain and the synchronous reset of the design.
*/
`timescale 1ns/1ns
`default_nettype none
module rpi_panel_asserts
   import rpi_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_close_malf,
   input wire rpi_pins_t i_pins,
   input wire rpi_cmd_t o_cmd,
   input wire rpi_prof_t o_prof,
   input wire rpi_leds_t o_leds
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   // ****************
   // Interlocks
   // ****************
   tag_blocks_close_a: assert property (
      o_prof.hlt_one_shot [*2] |-> o_cmd.close == 3'h0) else $error("close under tag");
   malf_blocks_close_a: assert property (
      $past(i_close_malf) |-> o_cmd.close == 3'h0) else $error("close under alarm");
   tag_no_trip_a: assert property (
      $rose(o_prof.hlt_one_shot) |-> o_cmd.trip == 3'h0) else $error("tag tripped");
   tag_priority_a: assert property (
      o_prof.hlt_one_shot |-> !(o_prof.cold_load_pickup | o_prof.non_recl | o_prof.fast_off))
      else $error("tag not on top");
   tag_led_lit_a: assert property (
      o_prof.hlt_one_shot [*2] |-> o_leds.hlt) else $error("tag led dark");
   scada_tag_a: assert property (
      i_pins.scada_hlt [*8] |-> o_prof.hlt_one_shot) else $error("scada tag lost");
   // Pins pass a three-stage synchroniser, hence the slack
   trip_button_a: assert property (
      $rose(i_pins.trip_pb) |-> ##[2:8] o_cmd.trip != 3'h0) else $error("no trip");
   close_button_a: assert property (
      $rose(i_pins.close_pb) && !i_close_malf && !o_prof.hlt_one_shot
      |-> ##[2:8] o_cmd.seq_home != 3'h0) else $error("no home");
   handle_trip_a: assert property (
      $rose(i_pins.handle_open[1]) |-> ##[2:8] o_cmd.trip[1]) else $error("handle ignored");
   cover property (o_cmd.trip == 3'h7);
   cover property (o_cmd.close != 3'h0);
   cover property ($rose(o_prof.gnd_off));
endmodule
bind rpi_panel rpi_panel_asserts rpi_panel_asserts_inst (.i_core_clk(i_core_clk),
   .i_srst(i_srst), .i_close_malf(i_close_malf), .i_pins(i_pins), .o_cmd(o_cmd),
   .o_prof(o_prof), .o_leds(o_leds));
`default_nettype wire

// ---- bench/rpi_far_model.sv ----
/*
 Far side of the panel interlock: panel switches, discrete pins and the recloser.
 Assumes tasks are called from the bench; pins change just after a rising edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rpi_far_model
   import rpi_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire rpi_cmd_t i_cmd,
   output var rpi_pins_t o_pins,
   output var rpi_prot_t o_prot
);
   logic [2:0] closed_q = 3'h0;
   logic [11:0] prot_q = 12'h000;
   initial o_pins = '0;
   assign o_prot = {prot_q[11:3], closed_q, prot_q[2:0]};
   // ****************
   // Recloser
   // ****************
   // Only a close command closes a pole; handles can only open it
   always @(posedge i_core_clk)
   begin
      closed_q <= i_srst ? 3'h0 : (closed_q | i_cmd.close) & ~i_cmd.trip & ~o_pins.handle_open;
   end
   // ****************
   // Panel
   // ****************
   // Held long enough to clear the synchroniser on both edges
   task automatic press(input int i);
      @(posedge i_core_clk);
      o_pins[i] <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      o_pins[i] <= 1'b0;
      repeat (8) @(posedge i_core_clk);
   endtask
   task automatic hold(input int i, input logic v);
      @(posedge i_core_clk);
      o_pins[i] <= v;
      repeat (10) @(posedge i_core_clk);
   endtask
   // Protection sequence levels: {pickup, curve trip, reclose, sequence lockout}
   task automatic fault(input logic [11:0] v);
      @(posedge i_core_clk);
      prot_q <= v;
   endtask
endmodule
`default_nettype wire

// ---- bench/test_recloser_panel_interlock.sv ----
/*
 Self-checking bench of the panel interlock.
 Assumes the far-side model and the bound checker; short window and idle counts.
*/
`timescale 1ns/1ns
`default_nettype none
module test_recloser_panel_interlock
   import rpi_pkg::*;
;
   localparam int PW = 200;
   localparam int PS = 500;
   localparam int I_SCADA = 2;
   localparam int I_HND = 3;
   localparam int I_FK = 6;
   localparam int I_CHG = 15;
   localparam int I_CLS = 16;
   localparam int I_TRP = 17;
   localparam int I_TAG = 18;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [AW-1:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic malf = 1'b0;
   logic [31:0] rdata;
   rpi_pins_t pins;
   rpi_prot_t prot;
   rpi_cmd_t cmd;
   rpi_prof_t prof;
   rpi_leds_t leds;
   rpi_cmd_t seen;
   int errors = 0;
   int tests_run = 0;
   rpi_panel #(.P_WINDOW_CYC(TW'(PW)), .P_PSAVE_CYC(TW'(PS)), .P_CYC_PER_MS(MSW'(10)))
   rpi_panel_inst (.i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_pins(pins), .i_prot(prot),
      .i_close_malf(malf), .o_cmd(cmd), .o_prof(prof), .o_leds(leds));
   rpi_far_model rpi_far_model_inst (.i_core_clk(clk), .i_srst(srst), .i_cmd(cmd),
      .o_pins(pins), .o_prot(prot));
   initial
   begin
      forever #5 clk = ~clk;
   end
   // Commands are single pulses, so they are gathered between checks
   always @(posedge clk) seen <= seen | cmd;
   // ****************
   // Helpers
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // Read data stand only in this cycle, so look mid-cycle
      @(negedge clk);
      chk(rdata & m, e);
   endtask
   task automatic pr(input int i);
      @(negedge clk);
      seen = '0;
      rpi_far_model_inst.press(i);
   endtask
   task automatic hd(input int i, input logic v);
      @(negedge clk);
      seen = '0;
      rpi_far_model_inst.hold(i, v);
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_regs();
      rdc(ADDR_CTRL, 32'h1F, 32'h4);
      rdc(ADDR_HLT_DLY, 32'hFFFF, 32'h0);
      wrr(8'h10, 32'hF);
      rdc(8'h10, 32'hFFFFFFFF, 32'h0);
      rdc(ADDR_CTRL, 32'h1F, 32'h4);
      wrr(ADDR_HLT_DLY, 32'h1234);
      rdc(ADDR_HLT_DLY, 32'hFFFF, 32'h1234);
      rdc(ADDR_CMD, 32'hFFFFFFFF, 32'h0);
   endtask
   task automatic t_button();
      pr(I_TRP);
      chk(32'(seen.trip), 32'h7);
      rdc(ADDR_STATUS, 32'h70, 32'h70);
      pr(I_CLS);
      chk(32'({seen.close, seen.seq_home}), 32'h3F);
      rdc(ADDR_STATUS, 32'h70, 32'h0);
   endtask
   task automatic t_tag();
      hd(I_TAG, 1'b1);
      wrr(ADDR_CMD, 32'h2);
      rdc(ADDR_STATUS, 32'h100007, 32'h100001);
      hd(I_SCADA, 1'b1);
      hd(I_TAG, 1'b0);
      rdc(ADDR_STATUS, 32'h100007, 32'h100004);
      pr(I_CLS);
      chk(32'({seen.close, seen.trip}), 32'h0);
      hd(I_SCADA, 1'b0);
      rdc(ADDR_STATUS, 32'h100000, 32'h0);
   endtask
   task automatic t_hot();
      wrr(ADDR_HLT_DLY, 32'h3);
      hd(I_TAG, 1'b1);
      rpi_far_model_inst.fault(12'hE00);
      repeat (20) @(posedge clk);
      chk(32'(seen.trip), 32'h0);
      repeat (20) @(posedge clk);
      chk(32'(seen.trip), 32'h7);
      rpi_far_model_inst.fault(12'h000);
      hd(I_TAG, 1'b0);
   endtask
   task automatic t_malf();
      @(posedge clk);
      malf <= 1'b1;
      pr(I_CLS);
      chk(32'(seen.close), 32'h0);
      @(posedge clk);
      malf <= 1'b0;
      pr(I_CLS);
      chk(32'(seen.close), 32'h7);
   endtask
   task automatic t_win();
      pr(I_CHG);
      rdc(ADDR_STATUS, 32'h20000, 32'h20000);
      pr(I_FK + FK_GND);
      pr(I_FK + FK_NRC);
      chk(32'({prof.gnd_off, prof.non_recl}), 32'h2);
      chk(32'(leds.fkey[FK_GND+:2]), 32'h1);
      pr(I_CHG);
      repeat (PW + 20) @(posedge clk);
      pr(I_FK + FK_GND);
      chk(32'(prof.gnd_off), 32'h1);
      pr(I_CHG);
      pr(I_FK + FK_SUP);
      wrr(ADDR_CMD, 32'h700);
      repeat (4) @(posedge clk);
      chk(32'(seen.close), 32'h0);
      pr(I_TRP);
      chk(32'(seen.trip), 32'h7);
      pr(I_CHG);
      pr(I_FK + FK_SUP);
   endtask
   task automatic t_cold_load_pickup();
      wrr(ADDR_CTRL, 32'hC);
      pr(I_CLS);
      chk(32'(prof.cold_load_pickup), 32'h1);
      wrr(ADDR_CMD, 32'h40);
      pr(I_CLS);
      chk(32'(prof.cold_load_pickup), 32'h0);
   endtask
   task automatic t_phase();
      wrr(ADDR_CTRL, 32'h6);
      pr(I_CHG);
      pr(I_FK + FK_PHS);
      pr(I_TRP);
      chk(32'(seen.trip), 32'h1);
      hd(I_HND + 1, 1'b1);
      chk(32'(seen.trip), 32'h2);
      hd(I_HND + 1, 1'b0);
      wrr(ADDR_CTRL, 32'h4);
      hd(I_HND + 2, 1'b1);
      chk(32'(seen.trip), 32'h7);
      rdc(ADDR_STATUS, 32'h70, 32'h70);
      hd(I_HND + 2, 1'b0);
   endtask
   task automatic t_psave();
      hd(I_TAG, 1'b1);
      repeat (PS + 50) @(posedge clk);
      chk(32'(leds), 32'h1000);
      hd(I_TAG, 1'b0);
   endtask
   // ****************
   // Run
   // ****************
   task automatic print_verdict();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      t_regs();
      t_button();
      t_tag();
      t_hot();
      t_malf();
      t_win();
      t_cold_load_pickup();
      t_phase();
      t_psave();
      print_verdict();
   end
   // Whole run needs about fourteen hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
